// ==== inc/ass_pkg.sv ====
package ass_pkg;
    localparam int SpeedW = 16;
    localparam int PosW = 32;
    localparam logic [2:0] SelMax = 3'h7;
    localparam logic [2:0] SelEstopMin = 3'h4;
    localparam logic [15:0] StopSpeed = 16'h001E;
    localparam logic [15:0] SpeedSetMax = 16'h4E20;
    localparam logic [9:0] TorqueSetMax = 10'h1F4;
    localparam logic [9:0] EstopTimeMax = 10'h3E8;
    localparam int ClkHz = 10000000;
    localparam int MsPerSec = 1000;
    localparam int TickCycles = ClkHz / MsPerSec;
    localparam int ScaleNum = 6;
    localparam int ScaleDen = 5;

    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_DECEL = 4'h2,
        ST_ESTOP = 4'h4,
        ST_STOPPED = 4'h8
    } ass_state_e;

    typedef enum logic [1:0] {
        ACT_BRAKE = 2'h0,
        ACT_FREE = 2'h1,
        ACT_ESTOP = 2'h2
    } ass_action_e;
endpackage

// ==== inc/ass_tick_if.sv ====
interface ass_tick_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface

// ==== rtl/ass_ms_tick.sv ====
module ass_ms_tick #(
    parameter int Cycles = ass_pkg::TickCycles
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Millisecond enable
    ass_tick_if.src tickOut
);
    logic [15:0] count;

    if (Cycles < 1 || Cycles > 65535)
    begin
        $error("ass_ms_tick: Cycles out of range");
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            count <= 16'h0000;
            tickOut.tick <= 1'b0;
        end
        else if (count == 16'(Cycles - 1))
        begin
            count <= 16'h0000;
            tickOut.tick <= 1'b1;
        end
        else
        begin
            count <= count + 16'h0001;
            tickOut.tick <= 1'b0;
        end
    end
endmodule

// ==== rtl/ass_alarm_stop_sequencer.sv ====
// How it works
// - Alarm forces position control, halts command generation
// - Deviation clear makes command track feedback
// - Settings 0-3 pick brake or free per phase
// - Settings 4-7 with estop alarm do torque-limited stop
// - Non-estop alarm: brake for 4,6, free 5,7
// - Stopped: brake for 4,5, free 6,7
// - Deceleration ends at 30 r/min, stays stopped
// - Estop torque 0 uses normal torque limit
// - Speed above overspeed level raises overspeed alarm
// - Estop not done in time enters alarm state
// - Estop time zero means immediate stop
// - During estop, second overspeed level raises alarm
// - Estop alarm actively controls motor to stop
// - Second overspeed cuts drive, stops via action B
// - Non-estop alarm during estop abandons the sequence
module ass_alarm_stop_sequencer #(
    parameter int TickCycles = ass_pkg::TickCycles,
    parameter logic [15:0] MaxSpeed = 16'h1770
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Settings
    input wire logic [2:0] alarmStopSelect,
    input wire logic [9:0] estopTorqueLimit,
    input wire logic [9:0] normalTorqueLimit,
    input wire logic [15:0] overspeedLevel,
    input wire logic [15:0] secondOverspeedLevel,
    input wire logic [9:0] estopTimeLimit,
    // Alarm inputs
    input wire logic alarmEstop,
    input wire logic alarmNoEstop,
    // Feedback and host command
    input wire logic [15:0] motorSpeed,
    input wire logic [31:0] feedbackPos,
    input wire logic [31:0] hostCmdPos,
    input wire logic hostCmdValid,
    // Power stage
    output logic dynamicBrake,
    output logic driveEnable,
    output logic torqueLimitActive,
    output logic [9:0] torqueLimit,
    // Control and status
    output logic [31:0] cmdPos,
    output logic forcePosCtrl,
    output logic cmdGenHalt,
    output logic devClear,
    output logic overspeedAlarm,
    output logic secondOverspeedAlarm,
    output logic estopTimeoutAlarm,
    output logic alarmActive,
    output logic [3:0] stateOut
);
    ass_pkg::ass_state_e state;
    ass_pkg::ass_action_e decelAct;
    logic stopBrake;
    logic [9:0] msCount;
    logic [16:0] maxScaled;
    logic [15:0] osLimit;
    logic [15:0] os2Limit;
    logic overNow;
    logic over2Now;
    logic anyAlarm;
    logic stopBrakeSel;
    ass_pkg::ass_action_e decelSel;
    ass_tick_if msTick ();

    // Scaled default threshold must fit the speed width
    if (MaxSpeed == 16'h0000
        || (32'(MaxSpeed) * ass_pkg::ScaleNum) / ass_pkg::ScaleDen > 32'h0000FFFF)
    begin
        $error("ass_alarm_stop_sequencer: MaxSpeed out of range");
    end

    ass_ms_tick #(.Cycles(TickCycles)) uTick (
        .clk(clk),
        .rst_n(rst_n),
        .tickOut(msTick)
    );

    // Speed thresholds, zero setting meaning 1.2 x max speed
    assign maxScaled = 17'((32'(MaxSpeed) * ass_pkg::ScaleNum) / ass_pkg::ScaleDen);
    assign osLimit = (overspeedLevel == 16'h0000) ? maxScaled[15:0] : overspeedLevel;
    assign os2Limit = (secondOverspeedLevel == 16'h0000) ? maxScaled[15:0]
                      : secondOverspeedLevel;
    assign overNow = motorSpeed > osLimit;
    assign over2Now = (state == ass_pkg::ST_ESTOP) && (motorSpeed > os2Limit);
    assign anyAlarm = alarmEstop || alarmNoEstop || overNow;

    // Action selection for the alarm at hand
    always_comb
    begin
        stopBrakeSel = 1'b1;
        decelSel = ass_pkg::ACT_BRAKE;
        if (alarmStopSelect < ass_pkg::SelEstopMin)
        begin
            decelSel = alarmStopSelect[0] ? ass_pkg::ACT_FREE : ass_pkg::ACT_BRAKE;
            stopBrakeSel = !alarmStopSelect[1];
        end
        else
        begin
            stopBrakeSel = !alarmStopSelect[1];
            if ((alarmEstop || overNow) && !alarmNoEstop && estopTimeLimit != 10'h000)
                decelSel = ass_pkg::ACT_ESTOP;
            else
                decelSel = alarmStopSelect[0] ? ass_pkg::ACT_FREE : ass_pkg::ACT_BRAKE;
        end
    end

    // Sequence state
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state <= ass_pkg::ST_RUN;
            decelAct <= ass_pkg::ACT_BRAKE;
            stopBrake <= 1'b1;
        end
        else
        begin
            case (state)
                ass_pkg::ST_RUN:
                    if (anyAlarm)
                    begin
                        decelAct <= decelSel;
                        stopBrake <= stopBrakeSel;
                        state <= (decelSel == ass_pkg::ACT_ESTOP) ? ass_pkg::ST_ESTOP
                                 : ass_pkg::ST_DECEL;
                    end
                ass_pkg::ST_DECEL:
                    if (motorSpeed <= ass_pkg::StopSpeed)
                        state <= ass_pkg::ST_STOPPED;
                ass_pkg::ST_ESTOP:
                    if (alarmNoEstop || over2Now)
                    begin
                        decelAct <= alarmStopSelect[0] ? ass_pkg::ACT_FREE
                                    : ass_pkg::ACT_BRAKE;
                        state <= ass_pkg::ST_DECEL;
                    end
                    else if (motorSpeed <= ass_pkg::StopSpeed)
                        state <= ass_pkg::ST_STOPPED;
                    else if (msTick.tick && msCount + 10'h001 >= estopTimeLimit)
                    begin
                        decelAct <= alarmStopSelect[0] ? ass_pkg::ACT_FREE
                                    : ass_pkg::ACT_BRAKE;
                        state <= ass_pkg::ST_DECEL;
                    end
                ass_pkg::ST_STOPPED:
                    state <= ass_pkg::ST_STOPPED;
                default:
                    state <= ass_pkg::ST_RUN;
            endcase
        end
    end

    // Emergency stop time budget
    always_ff @(posedge clk)
    begin
        if (!rst_n || state != ass_pkg::ST_ESTOP)
            msCount <= 10'h000;
        else if (msTick.tick && msCount != ass_pkg::EstopTimeMax)
            msCount <= msCount + 10'h001;
    end

    // Alarm flags, held until reset
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            overspeedAlarm <= 1'b0;
            secondOverspeedAlarm <= 1'b0;
            estopTimeoutAlarm <= 1'b0;
            alarmActive <= 1'b0;
        end
        else
        begin
            if (overNow)
                overspeedAlarm <= 1'b1;
            if (over2Now)
                secondOverspeedAlarm <= 1'b1;
            if (state == ass_pkg::ST_ESTOP && !alarmNoEstop && !over2Now
                && motorSpeed > ass_pkg::StopSpeed
                && msTick.tick && msCount + 10'h001 >= estopTimeLimit)
                estopTimeoutAlarm <= 1'b1;
            if (anyAlarm || state != ass_pkg::ST_RUN)
                alarmActive <= 1'b1;
        end
    end

    // Power stage and position control outputs
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            dynamicBrake <= 1'b0;
            driveEnable <= 1'b1;
            torqueLimitActive <= 1'b0;
            torqueLimit <= 10'h000;
            forcePosCtrl <= 1'b0;
            cmdGenHalt <= 1'b0;
            devClear <= 1'b0;
            stateOut <= ass_pkg::ST_RUN;
        end
        else
        begin
            stateOut <= state;
            forcePosCtrl <= state != ass_pkg::ST_RUN;
            cmdGenHalt <= state != ass_pkg::ST_RUN;
            devClear <= state != ass_pkg::ST_RUN;
            torqueLimit <= (estopTorqueLimit == 10'h000) ? normalTorqueLimit
                           : estopTorqueLimit;
            case (state)
                ass_pkg::ST_ESTOP:
                begin
                    driveEnable <= 1'b1;
                    dynamicBrake <= 1'b0;
                    torqueLimitActive <= 1'b1;
                end
                ass_pkg::ST_DECEL:
                begin
                    driveEnable <= 1'b0;
                    dynamicBrake <= decelAct == ass_pkg::ACT_BRAKE;
                    torqueLimitActive <= 1'b0;
                end
                ass_pkg::ST_STOPPED:
                begin
                    driveEnable <= 1'b0;
                    dynamicBrake <= stopBrake;
                    torqueLimitActive <= 1'b0;
                end
                default:
                begin
                    driveEnable <= 1'b1;
                    dynamicBrake <= 1'b0;
                    torqueLimitActive <= 1'b0;
                end
            endcase
        end
    end

    // Command position: host while running, feedback once halted
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cmdPos <= 32'h00000000;
        else if (state != ass_pkg::ST_RUN)
            cmdPos <= feedbackPos;
        else if (hostCmdValid)
            cmdPos <= hostCmdPos;
    end

    chk_halt_forced: assert property (@(posedge clk) disable iff (!rst_n)
        state != ass_pkg::ST_RUN |=> forcePosCtrl && cmdGenHalt)
        else $error("position control not forced");
    chk_cmd_tracks: assert property (@(posedge clk) disable iff (!rst_n)
        state != ass_pkg::ST_RUN |=> cmdPos == $past(feedbackPos))
        else $error("command not tracking feedback");
    chk_stopped_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        state == ass_pkg::ST_STOPPED |=> state == ass_pkg::ST_STOPPED)
        else $error("left stopped phase");
    chk_decel_end: assert property (@(posedge clk) disable iff (!rst_n)
        state == ass_pkg::ST_DECEL && motorSpeed <= ass_pkg::StopSpeed
        |=> state == ass_pkg::ST_STOPPED)
        else $error("decel did not end at stop speed");
    chk_os_flag: assert property (@(posedge clk) disable iff (!rst_n)
        overNow |=> overspeedAlarm)
        else $error("overspeed not flagged");
    chk_estop_entry: assert property (@(posedge clk) disable iff (!rst_n)
        state == ass_pkg::ST_RUN && alarmEstop && !alarmNoEstop
        && alarmStopSelect >= ass_pkg::SelEstopMin && estopTimeLimit != 10'h000
        |=> state == ass_pkg::ST_ESTOP)
        else $error("estop not entered");
    chk_no_zero_estop: assert property (@(posedge clk) disable iff (!rst_n)
        state == ass_pkg::ST_RUN && estopTimeLimit == 10'h000
        |=> state != ass_pkg::ST_ESTOP)
        else $error("estop with zero time");
    chk_abandon_estop: assert property (@(posedge clk) disable iff (!rst_n)
        state == ass_pkg::ST_ESTOP && alarmNoEstop |=> state == ass_pkg::ST_DECEL)
        else $error("estop not abandoned");
    chk_estop_drive: assert property (@(posedge clk) disable iff (!rst_n)
        state == ass_pkg::ST_ESTOP |=> driveEnable && torqueLimitActive && !dynamicBrake)
        else $error("estop not driving");
    chk_torque_zero: assert property (@(posedge clk) disable iff (!rst_n)
        estopTorqueLimit == 10'h000 |=> torqueLimit == $past(normalTorqueLimit))
        else $error("zero torque setting not normal");
    chk_stop_brake: assert property (@(posedge clk) disable iff (!rst_n)
        state == ass_pkg::ST_STOPPED |=> dynamicBrake == $past(stopBrake) && !driveEnable)
        else $error("stopped brake wrong");
    chk_latch_hold: assert property (@(posedge clk) disable iff (!rst_n)
        state == ass_pkg::ST_DECEL |=> $stable(stopBrake) && $stable(decelAct))
        else $error("latched action changed");
endmodule

// ==== bench/ass_motor_model.sv ====
module ass_motor_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // From the sequencer
    input wire logic dynamicBrake,
    input wire logic driveEnable,
    input wire logic torqueLimitActive,
    input wire logic devClear,
    input wire logic [31:0] cmdPos,
    // Bench controls
    input wire logic [15:0] speedCmd,
    input wire logic speedLoad,
    input wire logic stuck,
    // Feedback and host command
    output logic [15:0] motorSpeed,
    output logic [31:0] feedbackPos,
    output logic [31:0] hostCmdPos,
    output logic hostCmdValid
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] drop;
    // Speed loss per cycle by power stage mode
    always_comb
    begin
        if (stuck || (driveEnable && !torqueLimitActive && !dynamicBrake)) drop = 16'h0000;
        else if (dynamicBrake) drop = 16'h0064;
        else if (driveEnable) drop = 16'h0032;
        else drop = 16'h000A;
    end
    always_ff @(posedge clk)
    begin
        if (!rst_n) motorSpeed <= 16'h03E8;
        else if (speedLoad) motorSpeed <= speedCmd;
        else motorSpeed <= (motorSpeed > drop) ? motorSpeed - drop : 16'h0000;
        if (!rst_n) feedbackPos <= 32'h00000000;
        else feedbackPos <= feedbackPos + {20'h00000, motorSpeed[15:4]};
    end
    // Host takes its coordinate back while deviation is cleared
    always_ff @(posedge clk)
    begin
        if (!rst_n) hostCmdPos <= 32'h00000000;
        else if (devClear) hostCmdPos <= cmdPos;
        else hostCmdPos <= hostCmdPos + 32'h00000010;
        hostCmdValid <= rst_n && !devClear;
    end
endmodule

// ==== bench/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] sel = 3'h0;
    logic [9:0] etq = 10'h000;
    logic [9:0] ntq = 10'h12C;
    logic [15:0] osl = 16'h4E20;
    logic [15:0] sol = 16'h4E20;
    logic [9:0] etm = 10'h005;
    logic aE = 1'b0;
    logic aN = 1'b0;
    logic [15:0] spd = 16'h0000;
    logic ld = 1'b0;
    logic stk = 1'b0;
    logic dynamicBrake, driveEnable, torqueLimitActive, forcePosCtrl, cmdGenHalt, devClear;
    logic overspeedAlarm, secondOverspeedAlarm, estopTimeoutAlarm, alarmActive, hostCmdValid;
    logic [9:0] torqueLimit;
    logic [3:0] stateOut;
    logic [15:0] motorSpeed;
    logic [31:0] cmdPos, feedbackPos, hostCmdPos;
    int errors = 0;
    int samples_checked = 0;
    int n;
    always #50 clk = ~clk;
    ass_alarm_stop_sequencer #(.TickCycles(4)) i_ass_alarm_stop_sequencer (
        .clk(clk), .rst_n(rst_n), .alarmStopSelect(sel), .estopTorqueLimit(etq),
        .normalTorqueLimit(ntq), .overspeedLevel(osl), .secondOverspeedLevel(sol),
        .estopTimeLimit(etm), .alarmEstop(aE), .alarmNoEstop(aN), .motorSpeed(motorSpeed),
        .feedbackPos(feedbackPos), .hostCmdPos(hostCmdPos), .hostCmdValid(hostCmdValid),
        .dynamicBrake(dynamicBrake), .driveEnable(driveEnable),
        .torqueLimitActive(torqueLimitActive), .torqueLimit(torqueLimit), .cmdPos(cmdPos),
        .forcePosCtrl(forcePosCtrl), .cmdGenHalt(cmdGenHalt), .devClear(devClear),
        .overspeedAlarm(overspeedAlarm), .secondOverspeedAlarm(secondOverspeedAlarm),
        .estopTimeoutAlarm(estopTimeoutAlarm), .alarmActive(alarmActive), .stateOut(stateOut));
    ass_motor_model i_ass_motor_model (
        .clk(clk), .rst_n(rst_n), .dynamicBrake(dynamicBrake), .driveEnable(driveEnable),
        .torqueLimitActive(torqueLimitActive), .devClear(devClear), .cmdPos(cmdPos),
        .speedCmd(spd), .speedLoad(ld), .stuck(stk), .motorSpeed(motorSpeed),
        .feedbackPos(feedbackPos), .hostCmdPos(hostCmdPos), .hostCmdValid(hostCmdValid));
    task automatic report_and_stop();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
        begin
            $display("RESULT: PASS");
        end
        else
        begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (e !== g)
        begin
            errors++;
            $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // Bounded wait for a state, cycles counted in n
    task automatic waitst(input logic [3:0] s);
        n = 0;
        while (stateOut !== s)
        begin
            @(negedge clk);
            n++;
            if (n > 300)
            begin
                chk("stateOut", s, stateOut);
                report_and_stop();
            end
        end
    endtask
    task automatic setup(input logic [2:0] s, input logic [9:0] tq, input logic [9:0] tm);
        @(posedge clk);
        rst_n <= 1'b0;
        aE <= 1'b0;
        aN <= 1'b0;
        stk <= 1'b0;
        sel <= s;
        etq <= tq;
        etm <= tm;
        osl <= 16'h4E20;
        sol <= 16'h4E20;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
    endtask
    task automatic alarm(input logic e);
        @(posedge clk);
        aE <= e;
        aN <= !e;
    endtask
    task automatic load(input logic [15:0] v);
        @(posedge clk);
        spd <= v;
        ld <= 1'b1;
        @(posedge clk);
        ld <= 1'b0;
    endtask
    // Stopped phase: brake mode, forced control, command follows feedback
    task automatic stopped(input logic [2:0] s);
        waitst(ass_pkg::ST_STOPPED);
        repeat (20) @(negedge clk);
        chk("stopBrake", !s[1], dynamicBrake);
        chk("driveEnable", 1'b0, driveEnable);
        chk("forcePosCtrl", 1'b1, forcePosCtrl);
        chk("cmdGenHalt", 1'b1, cmdGenHalt);
        chk("devClear", 1'b1, devClear);
        chk("cmdPos", feedbackPos, cmdPos);
    endtask
    task automatic t_table();
        for (int j = 0; j < 12; j++)
        begin
            setup(3'(j), 10'h000, 10'h005);
            alarm(j >= 8);
            waitst(ass_pkg::ST_DECEL);
            @(negedge clk);
            chk("decelBrake", !j[0], dynamicBrake);
            chk("driveEnable", 1'b0, driveEnable);
            chk("cmdGenHalt", 1'b1, cmdGenHalt);
            stopped(3'(j));
        end
    endtask
    task automatic t_estop();
        logic [9:0] tq;
        for (int i = 4; i < 8; i++)
        begin
            tq = (i == 4) ? 10'h000 : 10'h0C8;
            setup(3'(i), tq, 10'h3E8);
            alarm(1'b1);
            waitst(ass_pkg::ST_ESTOP);
            @(negedge clk);
            chk("driveEnable", 1'b1, driveEnable);
            chk("torqueLimitActive", 1'b1, torqueLimitActive);
            chk("torqueLimit", (tq == 10'h000) ? ntq : tq, torqueLimit);
            chk("forcePosCtrl", 1'b1, forcePosCtrl);
            @(posedge clk);
            sel <= 3'(i) ^ 3'h2;
            stopped(3'(i));
            load(16'h01F4);
            repeat (5) @(negedge clk);
            chk("stateOut", ass_pkg::ST_STOPPED, stateOut);
            chk("estopTimeoutAlarm", 1'b0, estopTimeoutAlarm);
        end
    endtask
    task automatic t_timeout();
        setup(3'h4, 10'h000, 10'h002);
        @(posedge clk);
        stk <= 1'b1;
        alarm(1'b1);
        waitst(ass_pkg::ST_ESTOP);
        waitst(ass_pkg::ST_DECEL);
        chk("timeoutWindow", 1'b1, n >= 4 && n <= 12);
        @(negedge clk);
        chk("estopTimeoutAlarm", 1'b1, estopTimeoutAlarm);
        chk("alarmActive", 1'b1, alarmActive);
        setup(3'h4, 10'h000, 10'h000);
        alarm(1'b1);
        waitst(ass_pkg::ST_DECEL);
        @(negedge clk);
        chk("torqueLimitActive", 1'b0, torqueLimitActive);
    endtask
    task automatic t_speed();
        setup(3'h4, 10'h000, 10'h3E8);
        @(posedge clk);
        osl <= 16'h0000;
        load(16'h1C20);
        repeat (5) @(negedge clk);
        chk("stateOut", ass_pkg::ST_RUN, stateOut);
        chk("overspeedAlarm", 1'b0, overspeedAlarm);
        load(16'h1C21);
        waitst(ass_pkg::ST_ESTOP);
        @(negedge clk);
        chk("overspeedAlarm", 1'b1, overspeedAlarm);
        setup(3'h5, 10'h000, 10'h3E8);
        @(posedge clk);
        sol <= 16'h07D0;
        stk <= 1'b1;
        alarm(1'b1);
        waitst(ass_pkg::ST_ESTOP);
        load(16'h07D1);
        waitst(ass_pkg::ST_DECEL);
        @(negedge clk);
        chk("secondOverspeedAlarm", 1'b1, secondOverspeedAlarm);
        chk("driveEnable", 1'b0, driveEnable);
        chk("dynamicBrake", 1'b0, dynamicBrake);
        setup(3'h6, 10'h000, 10'h3E8);
        @(posedge clk);
        stk <= 1'b1;
        alarm(1'b1);
        waitst(ass_pkg::ST_ESTOP);
        @(posedge clk);
        aN <= 1'b1;
        waitst(ass_pkg::ST_DECEL);
        @(negedge clk);
        chk("dynamicBrake", 1'b1, dynamicBrake);
        chk("alarmActive", 1'b1, alarmActive);
    endtask
    initial
    begin
        repeat (100000) @(posedge clk);
        errors++;
        report_and_stop();
    end
    initial
    begin
        t_table();
        t_estop();
        t_timeout();
        t_speed();
        report_and_stop();
    end
endmodule
